// ===== psb_host_model.sv
// bus master model that drives the sram's synchronous inputs
`timescale 1ns/1ps
module psb_host_model (
  input  wire logic        sys_clk,
  output logic      [15:0] address,
  output logic             processor_addr_strobe_n,
  output logic             controller_addr_strobe_n,
  output logic             burst_advance_n,
  output logic      [3:0]  byte_select_n,
  output logic             byte_write_enable_n,
  output logic             global_write_n,
  output logic             chip_select_a_n,
  output logic             chip_select_b,
  output logic             chip_select_c_n,
  output logic      [31:0] dq_drive
);
  //////////////////////////////////////////////////
  // released lines show garbage, not the last value
  task automatic idle();
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
    {global_write_n, byte_write_enable_n, byte_select_n} = 6'h3f;
    {chip_select_a_n, chip_select_b} = 2'h1;
    address = ~address;
    dq_drive = ~dq_drive;
  endtask
  initial begin
    address = 16'h0;
    dq_drive = 32'h0;
    chip_select_c_n = 1'h0;
    idle();
  end
  // ctl is {proc strobe, ctrl strobe, select a, select b}, wr is {global, byte enable, lanes}
  task automatic start(input logic [3:0] ctl, input logic [15:0] a, input logic [5:0] wr,
                       input logic [31:0] d);
    @(negedge sys_clk);
    {processor_addr_strobe_n, controller_addr_strobe_n} = ctl[3:2];
    {chip_select_a_n, chip_select_b} = ctl[1:0];
    {global_write_n, byte_write_enable_n, byte_select_n} = wr;
    address = a;
    dq_drive = d;
    @(negedge sys_clk);
    idle();
  endtask
endmodule

// ===== psb_mem.sv
// storage array with byte writes and a registered read port
`timescale 1ns/1ps
module psb_mem
  import psb_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 32
) (
  input wire logic sys_clk,
  psb_mem_if.mem   port
);
  logic [DW-1:0] array_reg [0:(1<<AW)-1];
  logic [DW-1:0] rdata_reg;

  assign port.rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // self-timed write started by the clock edge, no write pulse needed
  always_ff @(posedge sys_clk) begin
    for (int b = 0; b < DW/8; b++) begin
      if (port.wbe[b]) begin
        array_reg[port.addr][b*8 +: 8] <= port.wdata[b*8 +: 8];
      end
    end
  end

  // read data lands in the output register
  always_ff @(posedge sys_clk) begin
    if (port.rd_en) begin
      rdata_reg <= array_reg[port.addr];
    end
  end
endmodule

// ===== psb_mem_if.sv
// carrier between the sram control logic and its storage array
`timescale 1ns/1ps
interface psb_mem_if #(
  parameter int AW = 16,
  parameter int DW = 32
);
  logic [AW-1:0]   addr;
  logic [DW-1:0]   wdata;
  logic [DW/8-1:0] wbe;
  logic            rd_en;
  logic [DW-1:0]   rdata;
  modport ctrl (output addr, output wdata, output wbe, output rd_en, input rdata);
  modport mem  (input addr, input wdata, input wbe, input rd_en, output rdata);
endinterface

// ===== psb_pkg.sv
// types of the pipelined burst sram
package psb_pkg;
  typedef enum logic [1:0] {
    PSB_DESEL = 2'b01,
    PSB_SEL   = 2'b10
  } psb_state_t;
endpackage

// ===== psb_regs.svh
// constants of the pipelined burst sram: widths, reset values and burst coding
`ifndef PSB_REGS_SVH
`define PSB_REGS_SVH
`define PSB_ADDR_W      16
`define PSB_DATA_W      32
`define PSB_BYTES       4
`define PSB_BURST_W     2
`define PSB_WORDS       65536
`define PSB_CNT_RST     2'h0
`define PSB_WBE_NONE    4'h0
`define PSB_WBE_ALL     4'hf
`define PSB_STRAP_RST   1'h1
`endif

// ===== psb_sram.sv
// pipelined burst sram: input capture, burst counter, write control, output drive
`timescale 1ns/1ps
`include "psb_regs.svh"
// Behaviour
// - all synchronous inputs are captured into registers at the rising edge
// - read data comes out of an output register clocked on the rising edge
// - the array holds 64K words of 32 bits, one per 16-bit address
// - address loads only on a strobe with all three chip selects active
// - an access starts on either address strobe at a rising edge
// - burst order, interleaved or linear, follows a static strap input
// - a 2-bit wrapping counter starts from zero and is combined with the two low address bits
// - the counter steps when advance is sampled low, else holds
// - four active-low byte selects choose the bytes of a byte write
// - global write low writes all four bytes regardless of other enables
// - writes are self-timed from the clock edge, no external pulse
// - selected only with select a low, select b high, select c low
// - the processor strobe is ignored while select a is high
// - data pins stay undriven in the first clock of a read after deselect
// - an asynchronous active-low output enable gates the data pin drivers
// - strap low gives linear order, high gives interleaved; strap is static
// - with both strobes low and select a low only the processor strobe is obeyed
// - output data is the word addressed at the previous rising edge
module psb_sram
  import psb_pkg::*;
#(
  parameter int AW = `PSB_ADDR_W,
  parameter int DW = `PSB_DATA_W
) (
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  input  wire logic [AW-1:0]   address,
  input  wire logic            processor_addr_strobe_n,
  input  wire logic            controller_addr_strobe_n,
  input  wire logic            burst_advance_n,
  input  wire logic [DW/8-1:0] byte_select_n,
  input  wire logic            byte_write_enable_n,
  input  wire logic            global_write_n,
  input  wire logic            chip_select_a_n,
  input  wire logic            chip_select_b,
  input  wire logic            chip_select_c_n,
  input  wire logic            output_enable_n,
  input  wire logic            burst_order_strap,
  input  wire logic [DW-1:0]   dq_in,
  output logic      [DW-1:0]   dq_out,
  output logic                 dq_oe
);
  localparam int BW = `PSB_BURST_W;

  psb_state_t          state_reg, state_next;
  logic [AW-1:BW]      addr_hi_reg, addr_hi_next;
  logic [BW-1:0]       base_reg, base_next;
  logic [BW-1:0]       cnt_reg, cnt_next;
  logic [DW/8-1:0]     wbe_reg, wbe_next;
  logic [DW-1:0]       wdata_reg;
  logic                drive_reg, drive_next;
  logic                strap_meta_reg, strap_sync_reg;
  logic                selected, start_proc, start_ctrl, start, desel;
  logic [BW-1:0]       burst_low;
  logic                rd_issue;

  psb_mem_if #(.AW(AW), .DW(DW)) mem_bus ();

  psb_mem #(.AW(AW), .DW(DW)) u_mem (
    .sys_clk (sys_clk),
    .port    (mem_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_meta_reg <= `PSB_STRAP_RST;
      strap_sync_reg <= `PSB_STRAP_RST;
    end else begin
      strap_meta_reg <= burst_order_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // select decode and strobe priority
  always_comb begin
    selected   = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    start_proc = !processor_addr_strobe_n && !chip_select_a_n;
    start_ctrl = !start_proc && !controller_addr_strobe_n;
    start      = (start_proc || start_ctrl) && selected;
    desel      = (start_proc || start_ctrl) && !selected;
  end

  ////////////////////////////////////////////////////////////////////////////
  // address register, burst counter and state
  always_comb begin
    state_next   = state_reg;
    addr_hi_next = addr_hi_reg;
    base_next    = base_reg;
    cnt_next     = cnt_reg;
    if (start) begin
      state_next   = PSB_SEL;
      addr_hi_next = address[AW-1:BW];
      base_next    = address[BW-1:0];
      cnt_next     = `PSB_CNT_RST;
    end else if (desel) begin
      state_next = PSB_DESEL;
    end else if (state_reg == PSB_SEL && !burst_advance_n) begin
      cnt_next = cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= PSB_DESEL;
      addr_hi_reg <= '0;
      base_reg    <= `PSB_CNT_RST;
      cnt_reg     <= `PSB_CNT_RST;
    end else begin
      state_reg   <= state_next;
      addr_hi_reg <= addr_hi_next;
      base_reg    <= base_next;
      cnt_reg     <= cnt_next;
    end
  end

  always_comb begin
    if (strap_sync_reg) begin
      burst_low = base_reg ^ cnt_reg;
    end else begin
      burst_low = base_reg + cnt_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write enables and write data capture
  always_comb begin
    wbe_next = `PSB_WBE_NONE;
    if (start_proc) begin
      wbe_next = `PSB_WBE_NONE;
    end else if (!global_write_n) begin
      wbe_next = `PSB_WBE_ALL;
    end else if (!byte_write_enable_n) begin
      wbe_next = ~byte_select_n;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wbe_reg <= `PSB_WBE_NONE;
    end else begin
      wbe_reg <= wbe_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    wdata_reg <= dq_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // array access and output drive
  always_comb begin
    rd_issue       = (state_reg == PSB_SEL) && (wbe_reg == `PSB_WBE_NONE);
    mem_bus.addr   = {addr_hi_reg, burst_low};
    mem_bus.wdata  = wdata_reg;
    mem_bus.wbe    = (state_reg == PSB_SEL) ? wbe_reg : `PSB_WBE_NONE;
    mem_bus.rd_en  = rd_issue;
    drive_next     = rd_issue;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign dq_out = mem_bus.rdata;
  assign dq_oe  = drive_reg && !output_enable_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence seq_start;
    start;
  endsequence

  sequence seq_read;
    rd_issue;
  endsequence

  sequence seq_desel_start;
    state_reg == PSB_DESEL && start;
  endsequence

  property p_load;
    seq_start |=> addr_hi_reg == $past(address[AW-1:BW])
      && base_reg == $past(address[BW-1:0]);
  endproperty

  chk_addr_load: assert property (p_load)
    else $error("address not loaded on a qualified strobe");
  chk_addr_hold: assert property (!start |=> $stable(addr_hi_reg) && $stable(base_reg))
    else $error("address changed without a qualified strobe");
  chk_proc_ignored: assert property (
    chip_select_a_n && controller_addr_strobe_n |=> $stable(state_reg))
    else $error("processor strobe acted while select a high");
  chk_proc_priority: assert property (
    !processor_addr_strobe_n && !controller_addr_strobe_n && selected
    |=> wbe_reg == `PSB_WBE_NONE && cnt_reg == `PSB_CNT_RST)
    else $error("controller strobe obeyed over processor strobe");
  chk_burst_step: assert property (
    state_reg == PSB_SEL && !start && !desel && !burst_advance_n
    |=> cnt_reg == $past(cnt_reg) + 2'h1)
    else $error("burst counter did not step");
  chk_burst_hold: assert property (
    !start && burst_advance_n |=> $stable(cnt_reg))
    else $error("burst counter moved without advance");
  chk_burst_order: assert property (
    strap_sync_reg |-> mem_bus.addr[BW-1:0] == (base_reg ^ cnt_reg))
    else $error("interleaved order wrong");
  chk_global_write: assert property (
    !global_write_n && !start_proc |=> wbe_reg == `PSB_WBE_ALL)
    else $error("global write did not enable all bytes");
  chk_byte_write: assert property (
    global_write_n && !byte_write_enable_n && !start_proc
    |=> wbe_reg == ~$past(byte_select_n))
    else $error("byte write lanes wrong");
  chk_read_drive: assert property (seq_read |=> drive_reg)
    else $error("read data not driven one clock after issue");
  chk_first_mask: assert property (seq_desel_start |=> !drive_reg && !dq_oe)
    else $error("data driven in first clock after deselect");
  chk_linear_order: assert property (
    !strap_sync_reg |-> mem_bus.addr[BW-1:0] == BW'(base_reg + cnt_reg))
    else $error("linear order wrong");
endmodule

// ===== tb_pipelined_burst_cache_sram.sv
// self-checking bench for the pipelined burst sram
`timescale 1ns/1ps
module tb_pipelined_burst_cache_sram;
  typedef struct {
    logic [15:0] a;
    logic [5:0]  wr;
    logic [31:0] d;
    logic [31:0] exp;
  } psb_row_t;
  logic        sys_clk = 1'h0;
  logic        resetn = 1'h0;
  logic        output_enable_n = 1'h0;
  logic        burst_order_strap = 1'h1;
  logic [15:0] address;
  logic        processor_addr_strobe_n;
  logic        controller_addr_strobe_n;
  logic        burst_advance_n;
  logic [3:0]  byte_select_n;
  logic        byte_write_enable_n;
  logic        global_write_n;
  logic        chip_select_a_n;
  logic        chip_select_b;
  logic        chip_select_c_n;
  logic [31:0] dq_drive;
  logic [31:0] dq_in;
  logic [31:0] dq_out;
  logic        dq_oe;
  int          err_count = 0;
  int          total_checks = 0;
  psb_row_t    rows [5] = '{
    '{16'h0010, 6'h1f, 32'h11223344, 32'h11ee33cc},
    '{16'hfff3, 6'h1f, 32'ha5a5a5a5, 32'ha5a5a5a5},
    '{16'h0010, 6'h2a, 32'hffeeddcc, 32'h11ee33cc},
    '{16'hfff3, 6'h30, 32'h00000000, 32'ha5a5a5a5},
    '{16'h0011, 6'h0f, 32'h01020304, 32'h01020304}
  };
  //////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;
  assign dq_in = dq_oe ? dq_out : dq_drive;
  psb_host_model host (.sys_clk, .address, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .byte_select_n, .byte_write_enable_n, .global_write_n, .chip_select_a_n,
    .chip_select_b, .chip_select_c_n, .dq_drive);
  psb_sram dut (.sys_clk, .resetn, .address, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .byte_select_n, .byte_write_enable_n, .global_write_n, .chip_select_a_n,
    .chip_select_b, .chip_select_c_n, .output_enable_n, .burst_order_strap, .dq_in, .dq_out,
    .dq_oe);
  //////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    host.start(4'h5, a, 6'h3f, 32'h0);
    @(negedge sys_clk);
    check("read data", dq_out, exp);
    check("read drive", {31'h0, dq_oe}, 32'h1);
  endtask
  // ord holds the expected low address pair of each beat, beat 0 in the low bits
  task automatic burst(input logic [1:0] st, input logic [7:0] ord);
    host.start(4'h5, {14'h0040, st}, 6'h3f, 32'h0);
    // beat 0 shows twice: advance is first sampled at the edge that reads beat 0 again
    for (int i = 0; i < 5; i++) begin
      @(negedge sys_clk);
      check("burst beat", dq_out, 32'hb0 + ord[((i == 0) ? 0 : 2*i - 2) +: 2]);
      host.burst_advance_n = (i == 4);
    end
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    resetn = 1'h1;
    // output enable held high while writing so the bus carries write data
    output_enable_n = 1'h1;
    foreach (rows[i]) host.start(4'h9, rows[i].a, rows[i].wr, rows[i].d);
    output_enable_n = 1'h0;
    foreach (rows[i]) rd(rows[i].a, rows[i].exp);
    output_enable_n = 1'h1;
    for (int i = 0; i < 4; i++) host.start(4'h9, 16'h0100 + i[15:0], 6'h1f, 32'hb0 + i);
    output_enable_n = 1'h0;
    burst(2'h1, 8'hb1);
    burst(2'h3, 8'h1b);
    @(negedge sys_clk);
    burst_order_strap = 1'h0;
    repeat (4) @(negedge sys_clk);
    burst(2'h1, 8'h39);
    burst(2'h3, 8'h93);
    rd(16'h0010, 32'h11ee33cc);
    host.start(4'h7, 16'h0011, 6'h3f, 32'h0);
    @(negedge sys_clk);
    check("ignored strobe", {31'h0, dq_oe}, 32'h1);
    check("held address", dq_out, 32'h11ee33cc);
    host.start(4'h1, 16'h0010, 6'h1f, 32'hdeadbeef);
    @(negedge sys_clk);
    check("dual strobe", {31'h0, dq_oe}, 32'h1);
    rd(16'h0010, 32'h11ee33cc);
    host.start(4'h8, 16'h0010, 6'h3f, 32'h0);
    @(negedge sys_clk);
    check("deselect", {31'h0, dq_oe}, 32'h0);
    host.chip_select_c_n = 1'h1;
    host.start(4'h5, 16'h0010, 6'h3f, 32'h0);
    @(negedge sys_clk);
    check("select c", {31'h0, dq_oe}, 32'h0);
    host.chip_select_c_n = 1'h0;
    host.start(4'h5, 16'h0011, 6'h3f, 32'h0);
    check("first read", {31'h0, dq_oe}, 32'h0);
    @(negedge sys_clk);
    check("next read", dq_out, 32'h01020304);
    check("next drive", {31'h0, dq_oe}, 32'h1);
    output_enable_n = 1'h1;
    #1 check("async enable", {31'h0, dq_oe}, 32'h0);
    @(negedge sys_clk);
    output_enable_n = 1'h0;
    resetn = 1'h0;
    #1 check("reset drive", {31'h0, dq_oe}, 32'h0);
    @(negedge sys_clk);
    resetn = 1'h1;
    rd(16'hfff3, 32'ha5a5a5a5);
    give_verdict();
  end
endmodule
